/* logic/ids_pkg.sv */
// Purpose: Shared constants and types for the injector driver supervisor
// Assumes: 200 MHz system clock, classic Wishbone register access
// Notes:   All offsets are byte addresses of 32-bit aligned words
package ids_pkg;
    // Clock and documented time limits
    localparam int unsigned CLK_PERIOD_NS   = 5;
    localparam int unsigned HV_WIN_MAX_NS   = 400_000;
    localparam int unsigned BACK_WIN_MAX_NS = 1_600_000;
    localparam int unsigned WIN_W           = 19;

    // Register map
    localparam int unsigned ADDR_W     = 8;
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_CMD      = 8'h04;
    localparam logic [7:0] OFF_BOOST    = 8'h08;
    localparam logic [7:0] OFF_CURR     = 8'h0C;
    localparam logic [7:0] OFF_HV_WIN   = 8'h10;
    localparam logic [7:0] OFF_BACK_WIN = 8'h14;
    localparam logic [7:0] OFF_PEAK_WIN = 8'h18;
    localparam logic [7:0] OFF_PROF     = 8'h1C;
    localparam logic [7:0] OFF_STATUS   = 8'h20;

    // Command bits (write one for a single-shot action)
    localparam int unsigned CMD_CAL_BIT = 0;
    localparam int unsigned CMD_CLR_BIT = 1;

    // Status word layout
    localparam int unsigned STAT_CAL_DONE    = 0;
    localparam int unsigned STAT_SHUTDOWN    = 1;
    localparam int unsigned STAT_INJ         = 2;
    localparam int unsigned STAT_BOOST       = 3;
    localparam int unsigned STAT_CRIT_LSB    = 8;
    localparam int unsigned STAT_NONCRIT_LSB = 16;

    // Critical fault index
    localparam int unsigned F_CHARGE   = 0;
    localparam int unsigned F_OVERLOAD = 1;
    localparam int unsigned F_SHORT    = 2;
    localparam int unsigned F_HV_STAGE = 3;
    localparam int unsigned F_LV_STAGE = 4;
    localparam int unsigned F_TEMP     = 5;
    localparam int unsigned F_OVERVOLT = 6;
    localparam int unsigned NUM_CRIT   = 7;
    localparam int unsigned NUM_PINF   = 5;

    // Analog limits in degrees C and volts, one LSB per unit; profile count limit and control reset value
    localparam logic [7:0] TEMP_LIMIT_C     = 8'h55;
    localparam logic [7:0] BOOST_LIMIT_V    = 8'h9B;
    localparam logic [7:0] EXT_HV_LIMIT_V   = 8'h06;
    localparam logic [1:0] PROF_COUNT_MAX   = 2'h2;
    localparam logic [7:0] CTRL_RESET       = 8'h00;

    // Control register, bit 0 is the gate
    typedef struct packed {
        logic [1:0] open_profile_select;
        logic [1:0] open_profile_count;
        logic       piezo_select;
        logic       current_only_sampling;
        logic       boost_supply_on;
        logic       injection_gate;
    } ids_ctrl_t;

    // Calibration download sequencing
    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_LOAD = 2'b01,
        CAL_DONE = 2'b10
    } ids_cal_state_t;
endpackage

/* logic/ids_supervisor.sv */
// Purpose: Supervisory control of a multi-channel injector driver
// Assumes: Fault pins are asynchronous; analog codes and fuel_cmd_i are synchronous
// Notes:   Outputs lag fuel_cmd_i by one clock
// Contract
// - Drivers act on fuel commands only while the gate is set; gate never fuels.
// - Boost supply runs while enabled and stops when disabled.
// - Boost set point is the injection target during injection, idle target otherwise.
// - Current-only mode samples current only, at double rate, during injection; else normal rate.
// - Current-only mode suspends boost during each injection, resumes afterward.
// - Calibration start loads parameters; done flag low until the load completes.
// - Profile count 0, 1, 2 loads one, two or three open profiles.
// - Profile select picks which loaded duty profile drives piezo current.
// - Piezo select enables piezo, disables solenoid; never both active.
// - High-voltage drive at pulse start for a window of up to 0.4 ms.
// - Back-EMF routed to boost at pulse end for up to 1.6 ms.
// - Peak current target during peak time, hold target until pulse end.
// - Any critical fault shuts down all operations.
// - Non-critical faults are only reported, never shut anything down.
// - Fault clear request tries to clear every set critical fault.
// - Board temperature above 85 C raises a critical fault.
// - Boost voltage above 155 V raises a critical fault.
// - External high voltage above 6 V shuts the boost supply down.
// - Short across injector outputs raises a critical fault.
// - Boost unable to raise its voltage raises a critical fault.
// - Boost loaded beyond long-term limit raises a critical fault.
// - Separate critical overload faults for high-voltage and battery stages.
//
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module ids_supervisor #(
    parameter int unsigned PROF_DEPTH   = 16,
    parameter int unsigned NONCRIT_W    = 4,
    parameter int unsigned PZ_STEP_CYC  = 200,
    parameter int unsigned HV_WIN_MAX   = ids_pkg::HV_WIN_MAX_NS / ids_pkg::CLK_PERIOD_NS,
    parameter int unsigned BACK_WIN_MAX = ids_pkg::BACK_WIN_MAX_NS / ids_pkg::CLK_PERIOD_NS
) (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [ids_pkg::ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    input  wire logic                      fuel_cmd_i,
    input  wire logic [7:0]                board_temp_i,
    input  wire logic [7:0]                boost_volt_i,
    input  wire logic [7:0]                ext_hv_volt_i,
    input  wire logic [ids_pkg::NUM_PINF-1:0] crit_pin_i,
    input  wire logic [NONCRIT_W-1:0]      noncrit_pin_i,
    output logic                           sol_drive_o,
    output logic                           piezo_drive_o,
    output logic                           hv_drive_o,
    output logic                           back_emf_o,
    output logic      [15:0]               current_target_o,
    output logic      [7:0]                piezo_duty_o,
    output logic                           boost_enable_o,
    output logic      [15:0]               boost_target_o,
    output logic                           sample_double_o,
    output logic                           voltage_ctrl_o,
    output logic                           cal_done_o,
    output logic                           shutdown_o,
    output logic      [ids_pkg::NUM_CRIT-1:0] crit_fault_o,
    output logic      [NONCRIT_W-1:0]      noncrit_fault_o
);
    localparam int unsigned PIN_W  = ids_pkg::NUM_PINF + NONCRIT_W;
    localparam int unsigned MEM_N  = 3 * PROF_DEPTH;
    localparam int unsigned PTR_W  = $clog2(MEM_N + 1);
    localparam int unsigned IDX_W  = $clog2(PROF_DEPTH);
    localparam int unsigned STEP_W = $clog2(PZ_STEP_CYC + 1);
    localparam int unsigned W      = ids_pkg::WIN_W;

    ids_pkg::ids_ctrl_t      ctrl;
    ids_pkg::ids_cal_state_t cal_state;
    logic [31:0]        boost_tgt;
    logic [31:0]        curr_tgt;
    logic [W-1:0]       hv_win;
    logic [W-1:0]       back_win;
    logic [W-1:0]       peak_win;
    logic [7:0]         prof_mem [MEM_N];
    logic [PTR_W-1:0]   wr_ptr;
    logic [PTR_W-1:0]   load_total;
    logic [PIN_W-1:0]   pin_s1;
    logic [PIN_W-1:0]   pin_s2;
    logic [PIN_W-1:0]   pin_s3;
    logic [PIN_W-1:0]   pin_filt;
    logic [ids_pkg::NUM_CRIT-1:0] crit_cause;
    logic [W-1:0]       pulse_cnt;
    logic [W-1:0]       back_cnt;
    logic               sol_q;
    logic [IDX_W-1:0]   pz_idx;
    logic [STEP_W-1:0]  pz_step;
    logic [31:0]        rdata;
    logic               wb_req;
    logic               wr_en;
    logic               cal_start;
    logic               fault_clear;
    logic               shutdown;
    logic               ext_hv_high;
    logic               inj_active;
    logic               sol_on;
    logic               pz_on;
    logic [1:0]         prof_sel;
    logic [PTR_W-1:0]   rd_addr;

    // Byte-lane merge of a write into an existing word
    function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Clamp a window to its documented maximum
    function automatic logic [W-1:0] wclamp(input logic [31:0] v, input int unsigned lim);
        logic [W-1:0] res;
        res = (v > 32'(lim)) ? W'(lim) : v[W-1:0];
        return res;
    endfunction

    // Bus decode; every access is acked, unmapped reads return zero
    assign wb_req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_en       = wb_req && wb_we_i;
    assign cal_start   = wr_en && (wb_adr_i == ids_pkg::OFF_CMD) && wb_sel_i[0]
                         && wb_dat_i[ids_pkg::CMD_CAL_BIT];
    assign fault_clear = wr_en && (wb_adr_i == ids_pkg::OFF_CMD) && wb_sel_i[0]
                         && wb_dat_i[ids_pkg::CMD_CLR_BIT];

    // Single-cycle ack, dropped the cycle after it was given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                wb_dat_o <= rdata;
            end
        end
    end

    // Read mux; status shows the block's live state
    always_comb begin
        rdata = 32'h0000_0000;
        unique case (wb_adr_i)
            ids_pkg::OFF_CTRL:     rdata = {24'h00_0000, ctrl};
            ids_pkg::OFF_BOOST:    rdata = boost_tgt;
            ids_pkg::OFF_CURR:     rdata = curr_tgt;
            ids_pkg::OFF_HV_WIN:   rdata = 32'(hv_win);
            ids_pkg::OFF_BACK_WIN: rdata = 32'(back_win);
            ids_pkg::OFF_PEAK_WIN: rdata = 32'(peak_win);
            ids_pkg::OFF_STATUS: begin
                rdata[ids_pkg::STAT_CAL_DONE] = cal_done_o;
                rdata[ids_pkg::STAT_SHUTDOWN] = shutdown;
                rdata[ids_pkg::STAT_INJ]      = sol_drive_o | piezo_drive_o;
                rdata[ids_pkg::STAT_BOOST]    = boost_enable_o;
                rdata[ids_pkg::STAT_CRIT_LSB +: ids_pkg::NUM_CRIT] = crit_fault_o;
                rdata[ids_pkg::STAT_NONCRIT_LSB +: NONCRIT_W]      = noncrit_fault_o;
            end
            default:               rdata = 32'h0000_0000;
        endcase
    end

    // Configuration registers; windows are clamped to their legal range
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl      <= ids_pkg::ids_ctrl_t'(ids_pkg::CTRL_RESET);
            boost_tgt <= 32'h0000_0000;
            curr_tgt  <= 32'h0000_0000;
            hv_win    <= '0;
            back_win  <= '0;
            peak_win  <= '0;
        end else if (wr_en) begin
            unique case (wb_adr_i)
                ids_pkg::OFF_CTRL: begin
                    if (wb_sel_i[0]) ctrl <= ids_pkg::ids_ctrl_t'(wb_dat_i[7:0]);
                end
                ids_pkg::OFF_BOOST:    boost_tgt <= wmerge(boost_tgt, wb_dat_i, wb_sel_i);
                ids_pkg::OFF_CURR:     curr_tgt  <= wmerge(curr_tgt, wb_dat_i, wb_sel_i);
                ids_pkg::OFF_HV_WIN:   hv_win    <= wclamp(wmerge(32'(hv_win), wb_dat_i,
                                                    wb_sel_i), HV_WIN_MAX);
                ids_pkg::OFF_BACK_WIN: back_win  <= wclamp(wmerge(32'(back_win), wb_dat_i,
                                                    wb_sel_i), BACK_WIN_MAX);
                ids_pkg::OFF_PEAK_WIN: peak_win  <= wclamp(wmerge(32'(peak_win), wb_dat_i,
                                                    wb_sel_i), (1 << W) - 1);
                default: ;
            endcase
        end
    end

    // Calibration download: start resets the pointer, profile words follow
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cal_state  <= ids_pkg::CAL_IDLE;
            wr_ptr     <= '0;
            load_total <= PTR_W'(PROF_DEPTH);
        end else if (cal_start) begin
            cal_state  <= ids_pkg::CAL_LOAD;
            wr_ptr     <= '0;
            // Counts above two are treated as three profiles
            load_total <= (ctrl.open_profile_count >= ids_pkg::PROF_COUNT_MAX)
                          ? PTR_W'(MEM_N)
                          : PTR_W'((ctrl.open_profile_count + 2'h1) * PROF_DEPTH);
        end else if (cal_state == ids_pkg::CAL_LOAD && wr_en
                     && wb_adr_i == ids_pkg::OFF_PROF) begin
            wr_ptr <= wr_ptr + 1'b1;
            if (wr_ptr + 1'b1 == load_total) begin
                cal_state <= ids_pkg::CAL_DONE;
            end
        end
    end

    // Profile memory has no reset; contents are valid once loaded
    always_ff @(posedge clk_i) begin
        if (cal_state == ids_pkg::CAL_LOAD && wr_en && wb_adr_i == ids_pkg::OFF_PROF
            && wb_sel_i[0] && !cal_start) begin
            prof_mem[wr_ptr] <= wb_dat_i[7:0];
        end
    end
    assign cal_done_o = (cal_state == ids_pkg::CAL_DONE);

    // Pin synchronisers: a change counts once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1   <= '0;
            pin_s2   <= '0;
            pin_s3   <= '0;
            pin_filt <= '0;
        end else begin
            pin_s1   <= {noncrit_pin_i, crit_pin_i};
            pin_s2   <= pin_s1;
            pin_s3   <= pin_s2;
            pin_filt <= (pin_filt & (pin_s2 ^ pin_s3)) | (pin_s3 & ~(pin_s2 ^ pin_s3));
        end
    end

    // Live fault causes from pins and analog codes
    always_comb begin
        crit_cause                      = '0;
        crit_cause[ids_pkg::F_CHARGE]   = pin_filt[ids_pkg::F_CHARGE];
        crit_cause[ids_pkg::F_OVERLOAD] = pin_filt[ids_pkg::F_OVERLOAD];
        crit_cause[ids_pkg::F_SHORT]    = pin_filt[ids_pkg::F_SHORT];
        crit_cause[ids_pkg::F_HV_STAGE] = pin_filt[ids_pkg::F_HV_STAGE];
        crit_cause[ids_pkg::F_LV_STAGE] = pin_filt[ids_pkg::F_LV_STAGE];
        crit_cause[ids_pkg::F_TEMP]     = board_temp_i > ids_pkg::TEMP_LIMIT_C;
        crit_cause[ids_pkg::F_OVERVOLT] = boost_volt_i > ids_pkg::BOOST_LIMIT_V;
    end

    // Sticky critical flags; a cause present in the clear cycle keeps its flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            crit_fault_o <= '0;
        end else begin
            crit_fault_o <= crit_cause | (fault_clear ? '0 : crit_fault_o);
        end
    end

    // Non-critical faults are reported live and feed no shutdown term
    assign noncrit_fault_o = pin_filt[PIN_W-1:ids_pkg::NUM_PINF];
    assign shutdown        = |crit_fault_o;
    assign shutdown_o      = shutdown;
    assign ext_hv_high     = ext_hv_volt_i > ids_pkg::EXT_HV_LIMIT_V;

    // Injection qualification: the gate only permits, fuel_cmd_i starts pulses
    assign inj_active = fuel_cmd_i && ctrl.injection_gate && !shutdown;
    assign sol_on     = inj_active && !ctrl.piezo_select;
    assign pz_on      = inj_active && ctrl.piezo_select;

    // Pulse-age and back-EMF counters for the solenoid channel
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sol_q     <= 1'b0;
            pulse_cnt <= '0;
            back_cnt  <= '0;
        end else begin
            sol_q <= sol_on;
            if (!sol_on) begin
                pulse_cnt <= '0;
            end else if (pulse_cnt != {W{1'b1}}) begin
                pulse_cnt <= pulse_cnt + 1'b1;
            end
            if (sol_on || shutdown) begin
                back_cnt <= '0;
            end else if (sol_q) begin
                back_cnt <= back_win;
            end else if (back_cnt != '0) begin
                back_cnt <= back_cnt - 1'b1;
            end
        end
    end
    assign back_emf_o = (back_cnt != '0);

    // Registered solenoid drive, high-voltage phase and current target
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sol_drive_o      <= 1'b0;
            hv_drive_o       <= 1'b0;
            current_target_o <= 16'h0000;
        end else begin
            sol_drive_o      <= sol_on;
            hv_drive_o       <= sol_on && (pulse_cnt < hv_win);
            current_target_o <= (pulse_cnt < peak_win) ? curr_tgt[15:0]
                                                       : curr_tgt[31:16];
        end
    end

    // Piezo profile walk; select is limited to the profiles that ctrl.open_profile_count names, at most three
    assign prof_sel = (ctrl.open_profile_select > ctrl.open_profile_count)
                      ? ((ctrl.open_profile_count > ids_pkg::PROF_COUNT_MAX)
                         ? ids_pkg::PROF_COUNT_MAX : ctrl.open_profile_count)
                      : ((ctrl.open_profile_select > ids_pkg::PROF_COUNT_MAX)
                         ? ids_pkg::PROF_COUNT_MAX : ctrl.open_profile_select);
    assign rd_addr  = PTR_W'(prof_sel * PROF_DEPTH) + PTR_W'(pz_idx);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            piezo_drive_o <= 1'b0;
            piezo_duty_o  <= 8'h00;
            pz_idx        <= '0;
            pz_step       <= '0;
        end else begin
            piezo_drive_o <= pz_on;
            piezo_duty_o  <= pz_on ? prof_mem[rd_addr] : 8'h00;
            if (!pz_on) begin
                pz_idx  <= '0;
                pz_step <= '0;
            end else if (pz_step == STEP_W'(PZ_STEP_CYC - 1)) begin
                pz_step <= '0;
                if (pz_idx != IDX_W'(PROF_DEPTH - 1)) pz_idx <= pz_idx + 1'b1;
            end else begin
                pz_step <= pz_step + 1'b1;
            end
        end
    end

    // Boost supply control and sampling mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            boost_enable_o  <= 1'b0;
            boost_target_o  <= 16'h0000;
            sample_double_o <= 1'b0;
            voltage_ctrl_o  <= 1'b0;
        end else begin
            boost_enable_o  <= ctrl.boost_supply_on && !shutdown && !ext_hv_high
                               && !(ctrl.current_only_sampling && inj_active);
            boost_target_o  <= inj_active ? boost_tgt[15:0] : boost_tgt[31:16];
            sample_double_o <= ctrl.current_only_sampling && inj_active;
            voltage_ctrl_o  <= !(ctrl.current_only_sampling && inj_active);
        end
    end

    sequence s_sol_start;
        !sol_q ##1 sol_q;
    endsequence

    AST_GATE_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl.injection_gate |=> !sol_drive_o && !piezo_drive_o)
        else $error("drive active without injection gate");
    AST_BOOST_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl.boost_supply_on |=> !boost_enable_o)
        else $error("boost running while disabled");
    AST_BOOST_TGT: assert property (@(posedge clk_i) disable iff (rst_i)
        inj_active |=> boost_target_o == $past(boost_tgt[15:0]))
        else $error("wrong boost set point during injection");
    AST_SUSPEND: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl.current_only_sampling && inj_active |=> !boost_enable_o && sample_double_o)
        else $error("boost not suspended in current-only mode");
    AST_EXCLUSIVE: assert property (@(posedge clk_i) disable iff (rst_i)
        !(sol_drive_o && piezo_drive_o))
        else $error("solenoid and piezo active together");
    AST_HV_START: assert property (@(posedge clk_i) disable iff (rst_i)
        s_sol_start ##0 ($past(hv_win) != '0) |-> hv_drive_o)
        else $error("high voltage phase missing at pulse start");
    AST_BACK_EMF: assert property (@(posedge clk_i) disable iff (rst_i)
        sol_q && !sol_on && !shutdown && back_win != '0 |=> back_emf_o)
        else $error("back-emf window not started at pulse end");
    AST_SHUTDOWN: assert property (@(posedge clk_i) disable iff (rst_i)
        shutdown |=> !boost_enable_o && !sol_drive_o && !piezo_drive_o)
        else $error("operation continues during critical fault");
    AST_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
        !fault_clear |=> (crit_fault_o & $past(crit_fault_o)) == $past(crit_fault_o))
        else $error("critical fault dropped without clear");
    AST_OVER_TEMP: assert property (@(posedge clk_i) disable iff (rst_i)
        board_temp_i > ids_pkg::TEMP_LIMIT_C |=> crit_fault_o[ids_pkg::F_TEMP])
        else $error("over temperature not flagged");
    AST_EXT_HV: assert property (@(posedge clk_i) disable iff (rst_i)
        ext_hv_high |=> !boost_enable_o)
        else $error("boost running with external high voltage");
    AST_CAL_START: assert property (@(posedge clk_i) disable iff (rst_i)
        cal_start |=> !cal_done_o)
        else $error("cal done not cleared on start");
endmodule

/* dv/ids_host.sv */
// Purpose: Host model, a classic Wishbone master
// Assumes: The slave acks within 16 clocks
// Notes:   stb_o drives both cyc and stb
`timescale 1ns/10ps
module ids_host (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] rdat_i,
    output logic             stb_o,
    output logic             we_o,
    output logic [7:0]       adr_o,
    output logic [31:0]      wdat_o
);
    int stalls = 0;
    // Idle bus from time zero so the slave never sees an unknown strobe
    initial begin
        stb_o  = 1'h0;
        we_o   = 1'h0;
        adr_o  = 8'h00;
        wdat_o = 32'h0000_0000;
    end
    // One cycle, held until ack is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        stb_o  <= 1'h1;
        we_o   <= w;
        adr_o  <= a;
        wdat_o <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_i !== 1'h1 && n < 16);
        if (ack_i !== 1'h1)
            stalls++;
        q = rdat_i;
        stb_o <= 1'h0;
        we_o  <= 1'h0;
    endtask
endmodule

/* dv/test_injector_driver_supervisor.sv */
// Purpose: Self-checking bench for the supervisor
// Assumes: Shortened windows and profile depth
// Notes:   Expected values follow from what is written
`timescale 1ns/10ps
module test_injector_driver_supervisor;
    logic        clk_i = 1'h0;
    logic        rst_i = 1'h1;
    logic        fuel  = 1'h0;
    logic [7:0]  temp  = 8'h00;
    logic [7:0]  ext   = 8'h00;
    logic [7:0]  bv    = 8'h00;
    logic [4:0]  cp    = 5'h00;
    logic [3:0]  ncp   = 4'h0;
    logic        stb, we, ack, sol, hv, boost, cald, shut, bemf, sdbl, vc, pz;
    logic [7:0]  adr, pzd;
    logic [3:0]  ncf;
    logic [31:0] wd, rd, q;
    logic [15:0] btgt, ctgt;
    logic [6:0]  crit;
    int          err_count = 0;
    int          num_checks = 0;
    ids_host h (.clk_i(clk_i), .ack_i(ack), .rdat_i(rd), .stb_o(stb), .we_o(we),
                .adr_o(adr), .wdat_o(wd));
    ids_supervisor #(.PROF_DEPTH(4), .PZ_STEP_CYC(2), .HV_WIN_MAX(20), .BACK_WIN_MAX(40)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(stb), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
        .fuel_cmd_i(fuel), .board_temp_i(temp), .boost_volt_i(bv), .ext_hv_volt_i(ext),
        .crit_pin_i(cp), .noncrit_pin_i(ncp), .sol_drive_o(sol), .piezo_drive_o(pz),
        .hv_drive_o(hv), .back_emf_o(bemf), .current_target_o(ctgt), .piezo_duty_o(pzd),
        .boost_enable_o(boost), .boost_target_o(btgt), .sample_double_o(sdbl),
        .voltage_ctrl_o(vc), .cal_done_o(cald), .shutdown_o(shut), .crit_fault_o(crit),
        .noncrit_fault_o(ncf));
    // 200 MHz clock
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic finish_test();
        err_count += h.stalls;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Tests in sequence; inputs change by NBA at rising edges or 1 ns after them
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        h.xfer(1'h1, 8'h08, 32'h0050_0096, q);
        h.xfer(1'h1, 8'h0C, 32'h0002_0001, q);
        h.xfer(1'h1, 8'h10, 32'h0000_0003, q);
        h.xfer(1'h1, 8'h14, 32'h0000_0002, q);
        h.xfer(1'h1, 8'h18, 32'h0000_0002, q);
        h.xfer(1'h1, 8'h00, 32'h0000_0007, q);
        tick(1);
        chk(boost, 32'h0000_0001);
        chk(btgt, 32'h0000_0050);
        h.xfer(1'h0, 8'hFC, 32'h0000_0000, q);
        chk(q, 32'h0000_0000);
        $display("bus test done");
        @(posedge clk_i);
        fuel <= 1'h1;
        tick(1);
        chk({sol, hv}, 32'h0000_0003);
        chk(btgt, 32'h0000_0096);
        chk({sdbl, vc, boost}, 32'h0000_0004);
        chk(ctgt, 32'h0000_0001);
        tick(3);
        chk(hv, 32'h0000_0000);
        chk(ctgt, 32'h0000_0002);
        fuel <= 1'h0;
        tick(1);
        chk(bemf, 32'h0000_0001);
        tick(2);
        chk(bemf, 32'h0000_0000);
        h.xfer(1'h1, 8'h00, 32'h0000_0002, q);
        fuel <= 1'h1;
        tick(2);
        chk(sol, 32'h0000_0000);
        fuel <= 1'h0;
        ext  <= 8'h07;
        tick(2);
        chk(boost, 32'h0000_0000);
        ext <= 8'h06;
        tick(2);
        chk(boost, 32'h0000_0001);
        $display("inject test done");
        temp <= 8'h56;
        tick(2);
        chk({shut, crit}, 32'h0000_00A0);
        chk(boost, 32'h0000_0000);
        h.xfer(1'h1, 8'h04, 32'h0000_0002, q);
        tick(1);
        chk(crit, 32'h0000_0020);
        temp <= 8'h55;
        h.xfer(1'h1, 8'h04, 32'h0000_0002, q);
        tick(1);
        chk({shut, crit}, 32'h0000_0000);
        ncp <= 4'h5;
        tick(6);
        chk({shut, ncf}, 32'h0000_0005);
        cp  <= 5'h1F;
        bv  <= 8'h9C;
        tick(6);
        chk({shut, crit}, 32'h0000_00DF);
        cp  <= 5'h00;
        bv  <= 8'h9B;
        tick(5);
        h.xfer(1'h1, 8'h04, 32'h0000_0002, q);
        tick(1);
        chk({shut, crit}, 32'h0000_0000);
        $display("fault test done");
        // One profile, then all three
        for (int n = 0; n < 2; n++) begin
            h.xfer(1'h1, 8'h00, 32'h0000_0020 * n, q);
            h.xfer(1'h1, 8'h04, 32'h0000_0001, q);
            tick(1);
            chk(cald, 32'h0000_0000);
            for (int i = 0; i < 4 + 8 * n; i++) begin
                h.xfer(1'h1, 8'h1C, 32'h0000_0010 + i, q);
                tick(1);
                chk(cald, (i == 3 + 8 * n));
            end
        end
        h.xfer(1'h1, 8'h00, 32'h0000_0069, q);
        fuel <= 1'h1;
        tick(1);
        chk({pz, sol, pzd}, 32'h0000_0214);
        fuel <= 1'h0;
        $display("cal test done");
        finish_test();
    end
endmodule
